// File: hw/exc_entry_pkg.sv
package exc_entry_pkg;

	// Fixed entry vectors
	localparam logic [31:0] VEC_RESET = 32'h0000_0000;
	localparam logic [31:0] VEC_BOOT = 32'h8000_0000;
	localparam logic [31:0] VEC_BREAK = 32'h0000_0010;
	localparam logic [31:0] VEC_UNDEF = 32'h0000_0020;
	localparam logic [31:0] VEC_MISALIGN = 32'h0000_0030;
	localparam logic [31:0] VEC_IRQ = 32'h0000_0080;
	localparam logic [31:0] VEC_IRQ_FLASH = 32'h0080_4000;

	// Return address alignment
	localparam logic [1:0] WORD_ALIGNED = 2'h0;
	localparam logic [31:0] RET_MASK = 32'hFFFF_FFFC;

	// Register map, byte addresses over a word-wide bus
	localparam int REG_AW = 4;
	localparam logic [REG_AW-1:0] REG_STATUS = 4'h0;
	localparam logic [REG_AW-1:0] REG_CONTROL = 4'h4;
	localparam logic [REG_AW-1:0] REG_RETURN = 4'h8;
	localparam logic [REG_AW-1:0] REG_CAUSE = 4'hC;

	// Field positions
	localparam int CTL_FLASH_EW_BIT = 0;
	localparam int ST_PSW_LSB = 0;
	localparam int ST_SAVED_LSB = 4;
	localparam int ST_BREAK_PEND_BIT = 8;
	localparam logic CTL_FLASH_EW_RST = 1'b0;

	// Kind of memory access of the executing instruction
	typedef enum logic [1:0] {
		MEM_NONE = 2'h0,
		MEM_HALF = 2'h1,
		MEM_WORD = 2'h2
	} mem_kind_t;

	// Last accepted entry
	typedef enum logic [2:0] {
		CAUSE_NONE = 3'h0,
		CAUSE_RESET = 3'h1,
		CAUSE_MISALIGN = 3'h3,
		CAUSE_UNDEF = 3'h2,
		CAUSE_BREAK = 3'h6,
		CAUSE_IRQ = 3'h7,
		CAUSE_RETURN = 3'h5
	} cause_t;

	typedef struct packed {
		logic stack_select;
		logic interrupt_enable;
		logic arith_flag;
	} psw_bits_t;

	localparam psw_bits_t PSW_CLEAR = '{1'b0, 1'b0, 1'b0};

	// Instruction in the execute stage
	typedef struct packed {
		logic valid;
		logic [31:0] pc;
		logic undefined;
		mem_kind_t mem_kind;
		logic [1:0] addr_lo;
		logic is_return;
	} ex_info_t;

	// Instruction boundary seen by the fetch side
	typedef struct packed {
		logic valid;
		logic [31:0] next_pc;
		logic prev_short_at_word;
		logic prev_branch;
	} boundary_t;

endpackage

// File: hw/cpu_exception_entry.sv
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01: Unimplemented op-code raises the undefined-opcode fault; the instruction does not execute.
// RULE_02: Undefined-opcode fault wins over a same-cycle peripheral request, which stays pending.
// RULE_03: Every fault, break and peripheral entry copies the three status bits into their saved copies.
// RULE_04: Fault entry keeps stack select, clears interrupt enable and arithmetic flag.
// RULE_05: Undefined-opcode entry stores the faulting instruction address; bit 1 marks halfword.
// RULE_06: Return from exception clears the two low bits of the restored address.
// RULE_07: Undefined-opcode entry redirects fetch to its own vector.
// RULE_08: Halfword access to address with low bits 01 or 11 is misaligned.
// RULE_09: Word access to address with low bits 01, 10 or 11 is misaligned.
// RULE_10: Misaligned access is suppressed and wins over a same-cycle peripheral request.
// RULE_11: Misaligned entry stores the faulting instruction address; bit 1 marks halfword.
// RULE_12: Misaligned entry redirects fetch to its own vector.
// RULE_13: Reset is taken in any cycle and outranks every other source.
// RULE_14: Reset fetches from zero, or from boot ROM base in boot mode.
// RULE_15: Break pin falling edge is accepted whatever the interrupt enable.
// RULE_16: Break is never taken right after a word-start short instruction, except branch target.
// RULE_17: Break and peripheral entry store the word-aligned current program counter.
// RULE_18: Break entry redirects fetch to the break vector.
// RULE_19: Peripheral request sampled at word boundaries, accepted only with interrupt enable set.
// RULE_20: Peripheral request never taken right after word-start short instruction, except branch target.
// RULE_21: Peripheral entry fetches its vector, or the RAM vector in flash write mode.
// RULE_22: The interrupt controller ranks sources and presents one request line.
// RULE_23: Return restores the status bits from saved copies and the counter from return address.
// RULE_24: Break and peripheral entry clear all three status bits after saving them.
// RULE_25: Reset clears all three status bits before the reset vector fetch.
module cpu_exception_entry
	import exc_entry_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Straps and pins
	input wire logic BOOT_MODE,
	input wire logic BREAK_N,
	// Interrupt controller request
	input wire logic IRQ_REQ,
	// Core pipeline
	input wire ex_info_t EX_INFO,
	input wire boundary_t BOUNDARY,
	output logic FETCH_REDIRECT,
	output logic [31:0] FETCH_VECTOR,
	output logic EX_CANCEL,
	output logic IRQ_ACK,
	output cause_t CAUSE,
	output psw_bits_t PROCESSOR_STATUS_WORD,
	output psw_bits_t SAVED_PSW,
	output logic [31:0] RETURN_ADDR,
	// Register bus
	input wire logic [REG_AW-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST
);

	function automatic logic misaligned(input mem_kind_t kind, input logic [1:0] lo);
		logic bad;
		bad = 1'b0;
		unique case (kind)
			MEM_HALF: bad = lo[0]; // RULE_08
			MEM_WORD: bad = (lo != WORD_ALIGNED); // RULE_09
			MEM_NONE: bad = 1'b0;
			default: bad = 1'b0;
		endcase
		return bad;
	endfunction

	psw_bits_t psw_r;
	psw_bits_t saved_r;
	logic [31:0] ret_r;
	logic reset_pend_r;
	logic break_prev_r;
	logic break_pend_r;
	logic flash_ew_r;
	logic redirect_r;
	logic [31:0] vector_r;
	logic cancel_r;
	logic irq_ack_r;
	cause_t cause_r;
	logic wait_r;
	logic [31:0] rdata_r;

	// Event decode, priority reset > misaligned > undefined > return > break > peripheral
	logic take_misalign;
	logic take_undef;
	logic take_return;
	logic boundary_ok;
	logic take_break;
	logic take_irq;
	logic break_fall;
	logic any_fault;

	assign take_misalign = EX_INFO.valid && !reset_pend_r && misaligned(EX_INFO.mem_kind, EX_INFO.addr_lo); // RULE_10
	assign take_undef = EX_INFO.valid && !reset_pend_r && EX_INFO.undefined && !take_misalign; // RULE_01
	assign any_fault = take_misalign || take_undef;
	assign take_return = EX_INFO.valid && !reset_pend_r && EX_INFO.is_return && !any_fault;
	assign boundary_ok = BOUNDARY.valid && (BOUNDARY.next_pc[1:0] == WORD_ALIGNED)
		&& !(BOUNDARY.prev_short_at_word && !BOUNDARY.prev_branch) // RULE_16 RULE_20
		&& !reset_pend_r && !any_fault && !take_return; // RULE_02
	assign take_break = boundary_ok && break_pend_r; // RULE_15
	assign take_irq = boundary_ok && !break_pend_r && IRQ_REQ && psw_r.interrupt_enable; // RULE_19
	assign break_fall = break_prev_r && !BREAK_N;

	// Bus writes commit at the edge after the wait state, while waitrequest is low
	logic bus_commit;
	logic status_wr;
	assign bus_commit = AVS_WRITE && !wait_r;
	assign status_wr = bus_commit && AVS_ADDRESS == REG_STATUS && AVS_BYTEENABLE[0];

	// First cycle after reset release fetches the reset vector
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			reset_pend_r <= 1'b1; // RULE_13
		end else begin
			reset_pend_r <= 1'b0;
		end
	end

	// Break pin edge capture; a new edge wins over acceptance
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			break_prev_r <= 1'b1;
			break_pend_r <= 1'b0;
		end else begin
			break_prev_r <= BREAK_N;
			if (break_fall) begin
				break_pend_r <= 1'b1; // RULE_15
			end else if (take_break) begin
				break_pend_r <= 1'b0;
			end
		end
	end

	// Status bits
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			psw_r <= PSW_CLEAR; // RULE_25
		end else if (reset_pend_r) begin
			psw_r <= PSW_CLEAR; // RULE_25
		end else if (any_fault) begin
			psw_r.interrupt_enable <= 1'b0; // RULE_04
			psw_r.arith_flag <= 1'b0; // RULE_04
		end else if (take_return) begin
			psw_r <= saved_r; // RULE_23
		end else if (take_break || take_irq) begin
			psw_r <= PSW_CLEAR; // RULE_24
		end else if (status_wr) begin
			psw_r <= psw_bits_t'(AVS_WRITEDATA[ST_PSW_LSB +: $bits(psw_bits_t)]);
		end
	end

	// Saved copies of the status bits
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			saved_r <= PSW_CLEAR;
		end else if (!reset_pend_r && (any_fault || take_break || take_irq)) begin
			saved_r <= psw_r; // RULE_03
		end else if (status_wr) begin
			saved_r <= psw_bits_t'(AVS_WRITEDATA[ST_SAVED_LSB +: $bits(psw_bits_t)]);
		end
	end

	// Return address
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ret_r <= VEC_RESET;
		end else if (any_fault) begin
			ret_r <= EX_INFO.pc; // RULE_05 RULE_11
		end else if (take_break || take_irq) begin
			ret_r <= BOUNDARY.next_pc; // RULE_17
		end
	end

	// Fetch redirect and cause
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			redirect_r <= 1'b0;
			vector_r <= VEC_RESET;
			cause_r <= CAUSE_NONE;
		end else begin
			redirect_r <= reset_pend_r || any_fault || take_return || take_break || take_irq;
			if (reset_pend_r) begin
				vector_r <= BOOT_MODE ? VEC_BOOT : VEC_RESET; // RULE_14
				cause_r <= CAUSE_RESET;
			end else if (take_misalign) begin
				vector_r <= VEC_MISALIGN; // RULE_12
				cause_r <= CAUSE_MISALIGN;
			end else if (take_undef) begin
				vector_r <= VEC_UNDEF; // RULE_07
				cause_r <= CAUSE_UNDEF;
			end else if (take_return) begin
				vector_r <= ret_r & RET_MASK; // RULE_06 RULE_23
				cause_r <= CAUSE_RETURN;
			end else if (take_break) begin
				vector_r <= VEC_BREAK; // RULE_18
				cause_r <= CAUSE_BREAK;
			end else if (take_irq) begin
				vector_r <= flash_ew_r ? VEC_IRQ_FLASH : VEC_IRQ; // RULE_21
				cause_r <= CAUSE_IRQ;
			end
		end
	end

	// Cancel of the faulting instruction and its memory access
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cancel_r <= 1'b0;
			irq_ack_r <= 1'b0;
		end else begin
			cancel_r <= any_fault; // RULE_01 RULE_10
			irq_ack_r <= take_irq;
		end
	end

	// Bus slave: one wait cycle, then the answer
	logic bus_req;
	assign bus_req = AVS_READ || AVS_WRITE;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= !(bus_req && wait_r);
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			flash_ew_r <= CTL_FLASH_EW_RST;
		end else if (bus_commit && AVS_ADDRESS == REG_CONTROL && AVS_BYTEENABLE[0]) begin
			flash_ew_r <= AVS_WRITEDATA[CTL_FLASH_EW_BIT];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_r <= '0;
		end else if (AVS_READ && wait_r) begin
			rdata_r <= '0;
			unique case (AVS_ADDRESS)
				REG_STATUS: begin
					rdata_r[ST_PSW_LSB +: 3] <= psw_r;
					rdata_r[ST_SAVED_LSB +: 3] <= saved_r;
					rdata_r[ST_BREAK_PEND_BIT] <= break_pend_r;
				end
				REG_CONTROL: rdata_r[CTL_FLASH_EW_BIT] <= flash_ew_r;
				REG_RETURN: rdata_r <= ret_r;
				REG_CAUSE: rdata_r[2:0] <= cause_r;
				default: rdata_r <= '0;
			endcase
		end
	end

	assign FETCH_REDIRECT = redirect_r;
	assign FETCH_VECTOR = vector_r;
	assign EX_CANCEL = cancel_r;
	assign IRQ_ACK = irq_ack_r;
	assign CAUSE = cause_r;
	assign PROCESSOR_STATUS_WORD = psw_r;
	assign SAVED_PSW = saved_r;
	assign RETURN_ADDR = ret_r;
	assign AVS_READDATA = rdata_r;
	assign AVS_WAITREQUEST = wait_r;

	// Checks
	property p_undef_entry;
		@(posedge CLK) disable iff (RST)
		take_undef |=> FETCH_REDIRECT && FETCH_VECTOR == VEC_UNDEF && RETURN_ADDR == $past(EX_INFO.pc) && EX_CANCEL;
	endproperty
	a_undef_entry: assert property (p_undef_entry) else $error("undefined opcode entry wrong"); // RULE_07

	property p_fault_psw;
		@(posedge CLK) disable iff (RST)
		any_fault |=> !PROCESSOR_STATUS_WORD.interrupt_enable && !PROCESSOR_STATUS_WORD.arith_flag && PROCESSOR_STATUS_WORD.stack_select == $past(psw_r.stack_select)
			&& SAVED_PSW == $past(psw_r);
	endproperty
	a_fault_psw: assert property (p_fault_psw) else $error("fault status update wrong"); // RULE_04

	property p_misalign_entry;
		@(posedge CLK) disable iff (RST)
		EX_INFO.valid && !reset_pend_r && EX_INFO.mem_kind == MEM_WORD && EX_INFO.addr_lo == 2'h2
			|=> FETCH_VECTOR == VEC_MISALIGN && EX_CANCEL && RETURN_ADDR == $past(EX_INFO.pc);
	endproperty
	a_misalign_entry: assert property (p_misalign_entry) else $error("word misaligned not taken"); // RULE_09

	property p_half_aligned;
		@(posedge CLK) disable iff (RST)
		EX_INFO.valid && EX_INFO.mem_kind == MEM_HALF && EX_INFO.addr_lo == 2'h2 && !EX_INFO.undefined
			|=> CAUSE != CAUSE_MISALIGN || !FETCH_REDIRECT;
	endproperty
	a_half_aligned: assert property (p_half_aligned) else $error("aligned halfword faulted"); // RULE_08

	property p_fault_beats_irq;
		@(posedge CLK) disable iff (RST)
		any_fault && IRQ_REQ |=> !IRQ_ACK ##1 PROCESSOR_STATUS_WORD.interrupt_enable == 1'b0;
	endproperty
	a_fault_beats_irq: assert property (p_fault_beats_irq) else $error("irq taken over fault"); // RULE_02

	property p_irq_masked;
		@(posedge CLK) disable iff (RST)
		!psw_r.interrupt_enable |=> !IRQ_ACK;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("irq taken while disabled"); // RULE_19

	property p_short_insn_gap;
		@(posedge CLK) disable iff (RST)
		BOUNDARY.prev_short_at_word && !BOUNDARY.prev_branch && !any_fault && !take_return && !reset_pend_r
			|=> !FETCH_REDIRECT;
	endproperty
	a_short_insn_gap: assert property (p_short_insn_gap) else $error("interrupt after short insn"); // RULE_20

	property p_break_entry;
		@(posedge CLK) disable iff (RST)
		take_break |=> FETCH_VECTOR == VEC_BREAK && PROCESSOR_STATUS_WORD == PSW_CLEAR && RETURN_ADDR[1:0] == WORD_ALIGNED;
	endproperty
	a_break_entry: assert property (p_break_entry) else $error("break entry wrong"); // RULE_18

	property p_irq_vector;
		@(posedge CLK) disable iff (RST)
		take_irq |=> IRQ_ACK && FETCH_VECTOR == ($past(flash_ew_r) ? VEC_IRQ_FLASH : VEC_IRQ) && SAVED_PSW.interrupt_enable;
	endproperty
	a_irq_vector: assert property (p_irq_vector) else $error("irq vector wrong"); // RULE_21

	property p_return;
		@(posedge CLK) disable iff (RST)
		take_return |=> FETCH_VECTOR[1:0] == WORD_ALIGNED && PROCESSOR_STATUS_WORD == $past(saved_r);
	endproperty
	a_return: assert property (p_return) else $error("return restore wrong"); // RULE_06

	property p_reset_vector;
		@(posedge CLK) disable iff (RST)
		reset_pend_r |=> FETCH_REDIRECT && PROCESSOR_STATUS_WORD == PSW_CLEAR && FETCH_VECTOR == ($past(BOOT_MODE) ? VEC_BOOT : VEC_RESET);
	endproperty
	a_reset_vector: assert property (p_reset_vector) else $error("reset vector wrong"); // RULE_14

	property p_irq_entry;
		@(posedge CLK) disable iff (RST)
		take_irq |=> PROCESSOR_STATUS_WORD == PSW_CLEAR && SAVED_PSW == $past(psw_r) && RETURN_ADDR == $past(BOUNDARY.next_pc);
	endproperty
	a_irq_entry: assert property (p_irq_entry) else $error("irq entry state wrong"); // RULE_17

	property p_misalign_beats_irq;
		@(posedge CLK) disable iff (RST)
		take_misalign && IRQ_REQ && psw_r.interrupt_enable |=> CAUSE == CAUSE_MISALIGN && !IRQ_ACK && EX_CANCEL;
	endproperty
	a_misalign_beats_irq: assert property (p_misalign_beats_irq) else $error("irq taken over misaligned access"); // RULE_10

	property p_break_latch;
		@(posedge CLK) disable iff (RST)
		break_fall |=> break_pend_r;
	endproperty
	a_break_latch: assert property (p_break_latch) else $error("break edge not latched"); // RULE_15

	property p_reset_priority;
		@(posedge CLK) disable iff (RST)
		reset_pend_r |=> CAUSE == CAUSE_RESET && !EX_CANCEL && !IRQ_ACK;
	endproperty
	a_reset_priority: assert property (p_reset_priority) else $error("reset did not outrank other sources"); // RULE_13

	property p_undef_cancel;
		@(posedge CLK) disable iff (RST)
		EX_INFO.valid && EX_INFO.undefined && !reset_pend_r |=> EX_CANCEL && FETCH_REDIRECT;
	endproperty
	a_undef_cancel: assert property (p_undef_cancel) else $error("undefined opcode not cancelled"); // RULE_01

	c_undef: cover property (@(posedge CLK) disable iff (RST) take_undef);
	c_break: cover property (@(posedge CLK) disable iff (RST) take_break ##[1:20] take_return);
	c_irq_flash: cover property (@(posedge CLK) disable iff (RST) take_irq && flash_ew_r);
	c_fault_irq: cover property (@(posedge CLK) disable iff (RST) any_fault && IRQ_REQ && psw_r.interrupt_enable);
	c_status_wr: cover property (@(posedge CLK) disable iff (RST) status_wr);

endmodule
`default_nettype wire

// File: verification/exc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module exc_far_side (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bench controls
	input wire logic brk_fire,
	input wire logic irq_raise,
	// Core side
	input wire logic irq_ack,
	output logic break_n,
	output logic irq_req
);
	logic brk_r;
	logic irq_r;

	// Break pin pulled up, low while fired
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			brk_r <= 1'b0;
		end else begin
			brk_r <= brk_fire;
		end
	end

	// One ranked request, held until accepted
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_r <= 1'b0;
		end else if (irq_ack) begin
			irq_r <= 1'b0;
		end else if (irq_raise) begin
			irq_r <= 1'b1;
		end
	end

	assign break_n = !brk_r;
	assign irq_req = irq_r;
endmodule
`default_nettype wire

// File: verification/tb_cpu_exception_entry.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_exception_entry
	import exc_entry_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic boot = 1'b0;
	logic brk_fire = 1'b0;
	logic irq_raise = 1'b0;
	wire logic break_n;
	wire logic irq_req;
	ex_info_t ex_drv = '0;
	boundary_t bd_drv = '0;
	logic redir, cancel, ack, waitreq;
	logic [31:0] vec, ret, rdata;
	cause_t cause;
	psw_bits_t processor_status_word, saved;
	logic [REG_AW-1:0] addr = '0;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = '0;
	logic [31:0] m_vec, m_ret, got;
	logic [2:0] m_psw, m_sav, m_cause;
	logic m_brk, m_flash;
	ex_info_t ex;
	int failures = 0;
	int checks = 0;
	int seed = 30;

	always #4 clk = ~clk;

	cpu_exception_entry i_dut (.CLK(clk), .RST(rst), .BOOT_MODE(boot), .BREAK_N(break_n), .IRQ_REQ(irq_req),
		.EX_INFO(ex_drv), .BOUNDARY(bd_drv), .FETCH_REDIRECT(redir), .FETCH_VECTOR(vec), .EX_CANCEL(cancel),
		.IRQ_ACK(ack), .CAUSE(cause), .PROCESSOR_STATUS_WORD(processor_status_word), .SAVED_PSW(saved), .RETURN_ADDR(ret), .AVS_ADDRESS(addr),
		.AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq));

	exc_far_side i_far (.clk(clk), .rst(rst), .brk_fire(brk_fire), .irq_raise(irq_raise), .irq_ack(ack),
		.break_n(break_n), .irq_req(irq_req));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic outs(input logic r, input logic c, input logic a);
		chk({31'h0, redir}, {31'h0, r}, "redirect");
		chk({31'h0, cancel}, {31'h0, c}, "cancel");
		chk({31'h0, ack}, {31'h0, a}, "ack");
		chk(vec, m_vec, "vector");
		chk(ret, m_ret, "return addr");
		chk({29'h0, processor_status_word}, {29'h0, m_psw}, "status");
		chk({29'h0, saved}, {29'h0, m_sav}, "saved");
		chk({29'h0, cause}, {29'h0, m_cause}, "cause");
	endtask

	task automatic core(input ex_info_t e, input boundary_t b);
		logic mis, und, rt, bok, brk, irq;
		@(posedge clk);
		ex_drv <= e;
		bd_drv <= b;
		@(posedge clk);
		mis = e.valid & (((e.mem_kind == MEM_HALF) & e.addr_lo[0]) | ((e.mem_kind == MEM_WORD) & (e.addr_lo != 2'h0)));
		und = e.valid & e.undefined & !mis;
		rt = e.valid & e.is_return & !mis & !und;
		bok = b.valid & (b.next_pc[1:0] == 2'h0) & !(b.prev_short_at_word & !b.prev_branch) & !(mis | und | rt);
		brk = bok & m_brk;
		irq = bok & !brk & irq_req & m_psw[1];
		ex_drv <= '0;
		bd_drv <= '0;
		if (mis | und | brk | irq) begin
			m_sav = m_psw;
			m_psw = (mis | und) ? {m_psw[2], 2'h0} : 3'h0;
			m_ret = (mis | und) ? e.pc : b.next_pc;
		end
		if (mis | und) begin
			m_vec = mis ? VEC_MISALIGN : VEC_UNDEF;
			m_cause = mis ? CAUSE_MISALIGN : CAUSE_UNDEF;
		end else if (rt) begin
			m_vec = m_ret & RET_MASK;
			m_psw = m_sav;
			m_cause = CAUSE_RETURN;
		end else if (brk | irq) begin
			m_vec = brk ? VEC_BREAK : (m_flash ? VEC_IRQ_FLASH : VEC_IRQ);
			m_cause = brk ? CAUSE_BREAK : CAUSE_IRQ;
			m_brk = m_brk & !brk;
		end
		#1;
		outs(mis | und | rt | brk | irq, mis | und, irq);
	endtask

	task automatic bus(input logic wr, input logic [REG_AW-1:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= wd;
		wr_en <= wr;
		rd_en <= !wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0);
		rd = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		chk(n, 32'h2, "bus latency");
	endtask

	task automatic do_reset(input logic b);
		@(posedge clk);
		rst <= 1'b1;
		boot <= b;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		m_psw = 3'h0;
		m_sav = 3'h0;
		m_ret = 32'h0;
		m_brk = 1'b0;
		m_flash = 1'b0;
		m_cause = CAUSE_RESET;
		m_vec = b ? VEC_BOOT : VEC_RESET;
		outs(1'b1, 1'b0, 1'b0);
		$display("reset test done");
	endtask

	initial begin
		do_reset(1'b0);
		irq_raise <= 1'b1;
		// Every access kind against every low address pair
		for (int k = 0; k < 3; k++) begin
			for (int a = 0; a < 4; a++) begin
				ex = '{1'b1, 32'($random(seed)), 1'($random(seed)), mem_kind_t'(k), 2'(a), 1'b0};
				core(ex, '0);
			end
		end
		$display("fault table test done");
		core('{1'b1, 32'h0000_0106, 1'b1, MEM_NONE, 2'h0, 1'b0}, '0);
		core('{1'b1, 32'h0000_0200, 1'b0, MEM_NONE, 2'h0, 1'b1}, '0);
		core('0, '{1'b1, 32'h0000_0300, 1'b0, 1'b0});
		$display("return and masked request test done");
		brk_fire <= 1'b1;
		repeat (3) @(posedge clk);
		brk_fire <= 1'b0;
		m_brk = 1'b1;
		bus(1'b0, REG_STATUS, 32'h0, got);
		chk(got, {23'h0, 1'b1, 1'b0, m_sav, 1'b0, m_psw}, "status reg");
		core('0, '{1'b1, 32'h0000_0404, 1'b1, 1'b0});
		core('0, '{1'b1, 32'h0000_0406, 1'b0, 1'b0});
		core('0, '{1'b1, 32'h0000_0408, 1'b1, 1'b1});
		$display("break test done");
		bus(1'b1, REG_STATUS, 32'h0000_0002, got);
		m_psw = 3'h2;
		m_sav = 3'h0;
		core('{1'b1, 32'h0000_0504, 1'b1, MEM_NONE, 2'h0, 1'b0}, '{1'b1, 32'h0000_0508, 1'b0, 1'b0});
		core('{1'b1, 32'h0000_0600, 1'b0, MEM_NONE, 2'h0, 1'b1}, '0);
		core('0, '{1'b1, 32'h0000_0700, 1'b0, 1'b0});
		$display("peripheral request test done");
		bus(1'b1, REG_CONTROL, 32'h1, got);
		m_flash = 1'b1;
		bus(1'b0, REG_CONTROL, 32'h0, got);
		chk(got, 32'h1, "control reg");
		bus(1'b1, REG_STATUS, 32'h0000_0002, got);
		m_psw = 3'h2;
		m_sav = 3'h0;
		core('{1'b1, 32'h0000_0906, 1'b0, MEM_WORD, 2'h1, 1'b0}, '{1'b1, 32'h0000_0908, 1'b0, 1'b0});
		core('{1'b1, 32'h0000_0A00, 1'b0, MEM_NONE, 2'h0, 1'b1}, '0);
		core('0, '{1'b1, 32'h0000_0800, 1'b0, 1'b1});
		bus(1'b1, REG_RETURN, 32'($random(seed)), got);
		bus(1'b0, REG_RETURN, 32'h0, got);
		chk(got, m_ret, "return reg");
		bus(1'b0, REG_CAUSE, 32'h0, got);
		chk(got, {29'h0, m_cause}, "cause reg");
		bus(1'b0, 4'h2, 32'h0, got);
		chk(got, 32'h0, "unmapped");
		$display("register test done");
		do_reset(1'b1);
		summarize;
	end

	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		summarize;
	end
endmodule
`default_nettype wire
